// [logic/rpd_core.sv]
// Mode, routing, clamp and servo control of the read pulse detector.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module rpd_core
  import rpd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_write_gate,
  input wire logic i_servo_field_select,
  input wire logic i_hold,
  input wire logic i_servo_switch_one,
  input wire logic i_servo_switch_two,
  input wire logic i_servo_switch_three,
  input wire logic i_servo_switch_four,
  input wire logic i_det_zero_cross,
  input wire logic i_ext_pulse_in,
  input wire logic i_signal_present,
  input wire logic i_qual_delayed,
  output logic o_amp_input_clamp,
  output logic o_agc_hold,
  output logic o_amp_input_block,
  output logic o_agc_update_en,
  output logic o_hyst_ref_servo_field,
  output logic [2:0] o_hyst_code,
  output logic [9:0] o_hyst_qual_x10,
  output logic o_ext_pulse_out_en,
  output logic o_ext_pulse_in_en,
  output logic o_ext_pulse_out,
  output logic o_sync_pulse,
  output logic o_test_mode,
  output logic o_fixed_gain,
  output logic o_osc_stop,
  output logic o_sync_clk_from_pins,
  output logic [3:0] o_servo_gate,
  output logic o_servo_discharge,
  output logic o_seek_mode,
  output logic o_obs_mode,
  output logic o_servo_cap_three_obs,
  output logic o_servo_cap_four_obs
);

  typedef struct packed {
    logic [12:0] cfg;
    logic [DATA_W-1:0] rdata;
    rpd_clamp_t clamp;
    logic [CNT_W-1:0] cnt;
    rpd_servo_t servo;
    logic [3:0] gate;
    logic disch;
    logic obs;
    logic bad;
    logic det_d;
    logic ext_d;
    logic agc_en;
    logic hyst_srv;
    logic [9:0] qual;
    logic cap3;
    logic cap4;
  } rpd_core_st_t;

  rpd_core_st_t st_ff;
  rpd_core_st_t nxt_st;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins;
  logic wg_act;
  logic hold_p;
  logic [3:0] sw;
  logic route_out;
  logic route_in;
  logic test_mode;
  logic clamp_on;
  logic [DATA_W-1:0] status;

  rpd_pulse_if det_if ();
  rpd_pulse_if ext_if ();

  assign pins_raw = {i_qual_delayed, i_signal_present, i_ext_pulse_in,
                     i_det_zero_cross, i_servo_switch_four,
                     i_servo_switch_three, i_servo_switch_two,
                     i_servo_switch_one, i_hold, i_servo_field_select,
                     i_write_gate ^ st_ff.cfg[CFG_WG_INV]};

  rpd_sync #(
    .W(PIN_W)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_pins(pins_raw),
    .o_level(pins)
  );

  rpd_shaper u_det_shaper (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .port(det_if.shp)
  );

  rpd_shaper u_ext_shaper (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .port(ext_if.shp)
  );

  // Write gate polarity follows the configuration so either board
  // convention works without an external inverter. It is applied ahead of
  // the synchroniser, whose reset level then always means no write, so no
  // false clamp follows reset.
  assign wg_act = pins[PIN_WG];
  assign hold_p = pins[PIN_HOLD];
  assign sw = pins[PIN_SW_HI:PIN_SW_LO];

  assign route_out = st_ff.cfg[CFG_ROUTE0] | st_ff.cfg[CFG_ROUTE1]; // R8
  assign route_in = st_ff.cfg[CFG_ROUTE1]; // R8
  assign test_mode = st_ff.cfg[CFG_ROUTE1] & st_ff.cfg[CFG_ROUTE0]; // R10

  // Edges of the synchronised pulses start the shapers.
  assign det_if.trig = pins[PIN_DET] & ~st_ff.det_d;
  assign ext_if.trig = pins[PIN_EXT] & ~st_ff.ext_d;

  assign clamp_on = (st_ff.clamp != RPD_CL_IDLE);

  always_comb begin
    status = '0;
    status[ST_CLAMP] = clamp_on;
    status[ST_WRITE] = (st_ff.clamp == RPD_CL_WRITE);
    status[ST_TEST] = test_mode;
    status[ST_SEEK] = (st_ff.servo == RPD_SV_SEEK);
    status[ST_OBS] = st_ff.obs;
    status[ST_DISCH] = st_ff.disch;
    status[ST_GATE_HI:ST_GATE_LO] = st_ff.gate;
    status[ST_BAD] = st_ff.bad;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.det_d = pins[PIN_DET];
    nxt_st.ext_d = pins[PIN_EXT];

    // Register port: read data stands only in the cycle after the strobe.
    nxt_st.rdata = '0;
    if (i_wr && i_addr == ADDR_CFG) begin
      nxt_st.cfg = (i_wdata[12:0] & CFG_WMASK) | (CFG_RST & ~CFG_WMASK);
    end
    if (i_rd) begin
      unique case (i_addr)
        ADDR_CFG: nxt_st.rdata = {3'h0, st_ff.cfg};
        ADDR_STAT: nxt_st.rdata = status;
        default: nxt_st.rdata = '0;
      endcase
    end

    // Input clamp: on during write, then a fixed hold once it ends.
    unique case (st_ff.clamp)
      RPD_CL_IDLE: begin
        if (wg_act) begin
          nxt_st.clamp = RPD_CL_WRITE; // R1
        end
      end
      RPD_CL_WRITE: begin
        if (!wg_act) begin
          nxt_st.clamp = RPD_CL_HOLD; // R1
          if (st_ff.cfg[CFG_SLOW]) begin // R2
            nxt_st.cnt = CNT_W'(CLAMP_SHORT_CYC - 1); // R3 R19
          end else begin
            nxt_st.cnt = CNT_W'(CLAMP_LONG_CYC - 1); // R3 R19
          end
        end
      end
      RPD_CL_HOLD: begin
        if (wg_act) begin
          nxt_st.clamp = RPD_CL_WRITE;
        end else if (st_ff.cnt == '0) begin
          nxt_st.clamp = RPD_CL_IDLE; // R1
        end else begin
          nxt_st.cnt = st_ff.cnt - CNT_W'(1); // R19
        end
      end
      default: nxt_st.clamp = RPD_CL_IDLE;
    endcase

    // The gain capacitor only tracks while a signal is present and the
    // channel is reading; otherwise its charge is left alone.
    nxt_st.agc_en = pins[PIN_SIG] & ~wg_act; // R4 R5

    nxt_st.hyst_srv = pins[PIN_SERVO_FIELD_SELECT]; // R6
    nxt_st.qual = QUAL_BASE_X10 + QUAL_STEP_X10 *
      (10'h007 - {7'h00, st_ff.cfg[CFG_HYST_HI:CFG_HYST_LO]}); // R7

    // Servo pins decode; nothing but these five pins moves the detectors.
    nxt_st.bad = 1'b0;
    if (hold_p) begin
      nxt_st.gate = sw; // R12 R17
      nxt_st.disch = 1'b0;
      nxt_st.obs = 1'b0;
    end else begin
      nxt_st.gate = 4'h0;
      nxt_st.disch = sw[3]; // R12 R16
      nxt_st.obs = sw[1]; // R14
      if (sw[0] && sw[2]) begin
        nxt_st.bad = 1'b1; // R18
      end else if (sw[0]) begin
        nxt_st.servo = RPD_SV_TRACK; // R13 R16
      end else if (sw[2]) begin
        nxt_st.servo = RPD_SV_SEEK; // R13 R16
      end
    end
    nxt_st.cap3 = nxt_st.obs & pins[PIN_DET]; // R15
    nxt_st.cap4 = nxt_st.obs & pins[PIN_QUAL]; // R15
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff <= '0;
      st_ff.cfg <= CFG_RST;
      st_ff.clamp <= RPD_CL_IDLE;
      st_ff.servo <= RPD_SV_TRACK;
      st_ff.qual <= QUAL_BASE_X10 + QUAL_STEP_X10 * 10'h002;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata = st_ff.rdata;
  assign o_amp_input_clamp = clamp_on; // R1
  assign o_agc_hold = (st_ff.clamp == RPD_CL_WRITE); // R4
  assign o_amp_input_block = (st_ff.clamp == RPD_CL_WRITE); // R4
  assign o_agc_update_en = st_ff.agc_en;
  assign o_hyst_ref_servo_field = st_ff.hyst_srv;
  assign o_hyst_code = st_ff.cfg[CFG_HYST_HI:CFG_HYST_LO];
  assign o_hyst_qual_x10 = st_ff.qual;
  assign o_ext_pulse_out_en = route_out;
  assign o_ext_pulse_in_en = route_in;
  assign o_ext_pulse_out = det_if.pulse & route_out; // R8
  // The internal path is cut whenever the external input is enabled.
  assign o_sync_pulse = route_in ? ext_if.pulse : det_if.pulse; // R9
  assign o_test_mode = test_mode;
  assign o_fixed_gain = test_mode; // R10
  assign o_osc_stop = test_mode; // R10
  assign o_sync_clk_from_pins = test_mode; // R10
  assign o_servo_gate = st_ff.gate;
  assign o_servo_discharge = st_ff.disch;
  assign o_seek_mode = (st_ff.servo == RPD_SV_SEEK); // R13
  assign o_obs_mode = st_ff.obs; // R14
  assign o_servo_cap_three_obs = st_ff.cap3;
  assign o_servo_cap_four_obs = st_ff.cap4;
endmodule
`default_nettype wire

// [logic/rpd_pkg.sv]
// Shared constants and types of the read pulse detector control block.
// Contract
// R1 - Clamp amplifier inputs during write gate and 1.7 or 3.4 us after it.
// R2 - Clamp duration comes from configuration bit 6.
// R3 - Duration bit one gives 1.7 us, zero gives 3.4 us.
// R4 - In write mode freeze the gain control voltage and block the input.
// R5 - Gain capacitor may change only while an input signal is present.
// R6 - Servo field input selects servo hysteresis reference, else data one.
// R7 - Three-bit code at bits 7 to 9 sets qualification 29 to 60.5 percent.
// R8 - Routing code bits 2,3: 00 none, 01 output, 1x output and input.
// R9 - Enabled external input replaces the internal path to the synchronizer.
// R10 - Both routing bits high: fixed gain, oscillators stop, pin clocks.
// R11 - Every detector output pulse is about 15 ns wide.
// R12 - Four servo peak detectors are steered only by five control pins.
// R13 - Track follow mode charges slowly, seek mode charges fast.
// R14 - Switch two high with hold low enters observation mode.
// R15 - Observation puts differentiator on pins 1,2, zero cross 3, qual 4.
// R16 - Hold low: switch one track, three seek, four discharge, else keep.
// R17 - Hold high: switch N gates detector N, latched mode kept.
// R18 - Forbidden switch one and three together leave the mode unchanged.
// R19 - Clamp hold timed by counter reloaded when write gate falls.
package rpd_pkg;

  localparam int CLK_PERIOD_PS = 4000;
  localparam int CLAMP_SHORT_US_X10 = 17;
  localparam int CLAMP_LONG_US_X10 = 34;
  localparam int PULSE_WIDTH_NS = 15;
  localparam int CLAMP_SHORT_CYC =
    (CLAMP_SHORT_US_X10 * 100000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CLAMP_LONG_CYC =
    (CLAMP_LONG_US_X10 * 100000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PULSE_CYC =
    (PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 10;
  localparam int PCNT_W = 3;

  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam int DATA_W = 16;

  localparam int CFG_ROUTE0 = 2;
  localparam int CFG_ROUTE1 = 3;
  localparam int CFG_PREAMBLE = 4;
  localparam int CFG_WG_INV = 5;
  localparam int CFG_SLOW = 6;
  localparam int CFG_HYST_LO = 7;
  localparam int CFG_HYST_HI = 9;
  localparam int CFG_SEQ_LO = 10;
  localparam int CFG_SEQ_HI = 12;
  localparam logic [12:0] CFG_RST = 13'h1EE3;
  localparam logic [12:0] CFG_WMASK = 13'h1FFC;

  localparam int ST_CLAMP = 0;
  localparam int ST_WRITE = 1;
  localparam int ST_TEST = 2;
  localparam int ST_SEEK = 3;
  localparam int ST_OBS = 4;
  localparam int ST_DISCH = 5;
  localparam int ST_GATE_LO = 6;
  localparam int ST_GATE_HI = 9;
  localparam int ST_BAD = 10;

  localparam logic [9:0] QUAL_BASE_X10 = 10'h122;
  localparam logic [9:0] QUAL_STEP_X10 = 10'h02D;

  localparam int PIN_W = 11;
  localparam int PIN_WG = 0;
  localparam int PIN_SERVO_FIELD_SELECT = 1;
  localparam int PIN_HOLD = 2;
  localparam int PIN_SW_LO = 3;
  localparam int PIN_SW_HI = 6;
  localparam int PIN_DET = 7;
  localparam int PIN_EXT = 8;
  localparam int PIN_SIG = 9;
  localparam int PIN_QUAL = 10;

  typedef enum logic [2:0] {
    RPD_CL_IDLE = 3'b001,
    RPD_CL_WRITE = 3'b010,
    RPD_CL_HOLD = 3'b100
  } rpd_clamp_t;

  typedef enum logic [1:0] {
    RPD_SV_TRACK = 2'b01,
    RPD_SV_SEEK = 2'b10
  } rpd_servo_t;

endpackage

// [logic/rpd_pulse_if.sv]
// Trigger and shaped pulse between the control core and a pulse shaper.
`timescale 1ns/10ps
`default_nettype none
interface rpd_pulse_if;
  logic trig;
  logic pulse;
  modport src (output trig, input pulse);
  modport shp (input trig, output pulse);
endinterface
`default_nettype wire

// [logic/rpd_shaper.sv]
// Fixed-width pulse generator started by a one-cycle trigger.
`timescale 1ns/10ps
`default_nettype none
module rpd_shaper
  import rpd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  rpd_pulse_if.shp port
);
  typedef struct packed {
    logic [PCNT_W-1:0] cnt;
    logic pulse;
  } rpd_shp_st_t;

  rpd_shp_st_t st_ff;
  rpd_shp_st_t nxt_st;

  // A retrigger restarts the width so a pulse is never cut short.
  always_comb begin
    nxt_st = st_ff;
    if (port.trig) begin
      nxt_st.cnt = PCNT_W'(PULSE_CYC - 1); // R11
      nxt_st.pulse = 1'b1;
    end else if (st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - PCNT_W'(1);
    end else begin
      nxt_st.pulse = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign port.pulse = st_ff.pulse;
endmodule
`default_nettype wire

// [logic/rpd_sync.sv]
// Three-stage pin synchroniser that accepts a level once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module rpd_sync
  import rpd_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_pins,
  output logic [W-1:0] o_level
);
  typedef struct packed {
    logic [W-1:0] stg1;
    logic [W-1:0] stg2;
    logic [W-1:0] stg3;
    logic [W-1:0] lvl;
  } rpd_sync_st_t;

  rpd_sync_st_t st_ff;
  rpd_sync_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.stg1 = i_pins;
    nxt_st.stg2 = st_ff.stg1;
    nxt_st.stg3 = st_ff.stg2;
    nxt_st.lvl = (st_ff.stg2 & st_ff.stg3) |
      (st_ff.lvl & (st_ff.stg2 ^ st_ff.stg3));
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_level = st_ff.lvl;
endmodule
`default_nettype wire

// [sim/rpd_chk.sv]
// Port assertions of the read pulse detector control core.
`timescale 1ns/10ps
`default_nettype none
module rpd_chk
  import rpd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_hold,
  input wire logic i_servo_switch_one,
  input wire logic i_servo_switch_two,
  input wire logic i_servo_switch_three,
  input wire logic i_servo_switch_four,
  input wire logic i_signal_present,
  input wire logic i_servo_field_select,
  input wire logic i_det_zero_cross,
  input wire logic i_qual_delayed,
  input wire logic o_hyst_ref_servo_field,
  input wire logic o_servo_cap_three_obs,
  input wire logic o_servo_cap_four_obs,
  input wire logic o_amp_input_clamp,
  input wire logic o_agc_hold,
  input wire logic o_amp_input_block,
  input wire logic o_agc_update_en,
  input wire logic [2:0] o_hyst_code,
  input wire logic [9:0] o_hyst_qual_x10,
  input wire logic o_ext_pulse_out_en,
  input wire logic o_ext_pulse_in_en,
  input wire logic o_ext_pulse_out,
  input wire logic o_test_mode,
  input wire logic [3:0] o_servo_gate,
  input wire logic o_servo_discharge,
  input wire logic o_seek_mode,
  input wire logic o_obs_mode
);
  logic slow_ff;
  logic [9:0] hold_ff;
  logic [4:0] p;
  assign p = {i_hold, i_servo_switch_four, i_servo_switch_three,
    i_servo_switch_two, i_servo_switch_one};
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // Mirrors the duration bit so the hold length is known exactly.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      slow_ff <= CFG_RST[CFG_SLOW];
      hold_ff <= 10'h000;
    end else begin
      if (i_wr && i_addr == ADDR_CFG)
        slow_ff <= i_wdata[CFG_SLOW];
      hold_ff <= (o_amp_input_clamp && !o_agc_hold) ? hold_ff + 10'h001
        : 10'h000;
    end
  end
  sequence s_quiet(v);
    ($stable(v)) [*7];
  endsequence
  a_route_en: assert property (
    (o_ext_pulse_in_en |-> o_ext_pulse_out_en)
    and (o_test_mode |-> o_ext_pulse_in_en))
    else $error("pin enables disagree");
  a_hyst_qual: assert property (
    $stable(o_hyst_code) |-> o_hyst_qual_x10 == QUAL_BASE_X10
      + QUAL_STEP_X10 * (10'h007 - {7'h00, o_hyst_code}))
    else $error("qualification level wrong");
  a_write_freeze: assert property (
    (o_amp_input_block == o_agc_hold) and (o_agc_hold |-> o_amp_input_clamp))
    else $error("write mode outputs disagree");
  a_clamp_len: assert property (
    $fell(o_amp_input_clamp) |-> hold_ff == (slow_ff
      ? CLAMP_SHORT_CYC : CLAMP_LONG_CYC))
    else $error("clamp hold length wrong");
  a_agc_idle: assert property (
    (!i_signal_present) [*7] |-> !o_agc_update_en)
    else $error("gain update without signal");
  a_pulse_width: assert property (
    $rose(o_ext_pulse_out) |-> o_ext_pulse_out [*4] ##1 !o_ext_pulse_out)
    else $error("pulse width wrong");
  a_servo_low: assert property (
    s_quiet(p) ##0 !p[4] |-> o_servo_discharge == p[3] && o_servo_gate == 0
      && o_obs_mode == p[1] && (p[0] == p[2] || o_seek_mode == p[2]))
    else $error("servo decode wrong");
  a_servo_gate: assert property (
    s_quiet(p) ##0 p[4] |-> o_servo_gate == p[3:0] && !o_obs_mode)
    else $error("servo gating wrong");
  a_mode_kept: assert property (
    s_quiet(p) ##0 (p[4] || p[0] == p[2]) |-> $stable(o_seek_mode))
    else $error("servo mode changed");
  a_hyst_ref: assert property (
    s_quiet(i_servo_field_select) |->
      o_hyst_ref_servo_field == i_servo_field_select)
    else $error("hysteresis reference wrong");
  a_obs_pins: assert property (
    s_quiet({p, i_det_zero_cross, i_qual_delayed}) |->
      o_servo_cap_three_obs == (o_obs_mode && i_det_zero_cross)
      && o_servo_cap_four_obs == (o_obs_mode && i_qual_delayed))
    else $error("observation pins wrong");
endmodule
bind rpd_core rpd_chk u_chk (.*);
`default_nettype wire

// [sim/rpd_far.sv]
// Behavioural far side: servo controller pins and pulse sources.
`timescale 1ns/10ps
`default_nettype none
module rpd_far (
  input wire logic i_clock,
  input wire logic [4:0] i_cmd,
  input wire logic i_bad,
  input wire logic [1:0] i_fire,
  output logic [4:0] o_pins,
  output logic [1:0] o_det
);
  logic [4:0] pins_ff = 5'h00;
  logic [5:0] fire_ff = 6'h00;
  // Switch one with three under low hold is applied only when told to.
  always @(posedge i_clock) begin
    if (i_bad || i_cmd[4] || !(i_cmd[0] && i_cmd[2]))
      pins_ff <= i_cmd;
    fire_ff <= {fire_ff[3:0], i_fire};
  end
  assign o_pins = pins_ff;
  // Three cycles wide, so a pin synchroniser cannot miss a pulse.
  assign o_det = fire_ff[1:0] | fire_ff[3:2] | fire_ff[5:4];
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the read pulse detector control core.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("Error %0t: got %0h want %0h", $time, g, e); end end
module tb_top
  import rpd_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [DATA_W-1:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_write_gate = 1'b1;
  logic i_servo_field_select = 1'b0;
  logic i_signal_present = 1'b0;
  logic qual = 1'b0;
  logic [4:0] cmd = 5'h00;
  logic bad = 1'b0;
  logic [1:0] fire = 2'h0;
  logic [4:0] pins;
  logic [1:0] det;
  logic [DATA_W-1:0] o_rdata;
  logic o_amp_input_clamp, o_agc_hold, o_amp_input_block, o_agc_update_en;
  logic o_hyst_ref_servo_field, o_ext_pulse_out_en, o_ext_pulse_in_en;
  logic o_ext_pulse_out, o_sync_pulse, o_test_mode, o_fixed_gain;
  logic o_osc_stop, o_sync_clk_from_pins, o_servo_discharge, o_seek_mode;
  logic o_obs_mode, o_servo_cap_three_obs, o_servo_cap_four_obs;
  logic [2:0] o_hyst_code;
  logic [9:0] o_hyst_qual_x10;
  logic [3:0] o_servo_gate;
  int failures = 0;
  int checks_done = 0;
  rpd_core DUT (.*, .i_hold(pins[4]), .i_servo_switch_four(pins[3]),
    .i_servo_switch_three(pins[2]), .i_servo_switch_two(pins[1]),
    .i_servo_switch_one(pins[0]), .i_det_zero_cross(det[0]),
    .i_ext_pulse_in(det[1]), .i_qual_delayed(qual));
  rpd_far FAR (.i_clock(i_clock), .i_cmd(cmd), .i_bad(bad), .i_fire(fire),
    .o_pins(pins), .o_det(det));
  always #2 i_clock = ~i_clock;
  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask
  task automatic settle;
    repeat (8) tick;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
  endtask
  task automatic count_high(ref logic s, input int lim, output int n);
    n = 0;
    while (s === 1'b1 && n < lim) begin
      tick;
      n++;
    end
  endtask
  task automatic pulse(input logic [1:0] f, output int no, output int ns);
    no = 0;
    ns = 0;
    @(posedge i_clock);
    fire <= f;
    @(posedge i_clock);
    fire <= 2'h0;
    repeat (16) begin
      tick;
      no += int'(o_ext_pulse_out === 1'b1);
      ns += int'(o_sync_pulse === 1'b1);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    failures++;
    tally_and_finish;
  end
  initial begin
    int n;
    int no;
    int ns;
    logic seek;
    logic [6:0] e;
    logic [6:0] g;
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'b1;
    rd(ADDR_CFG, {3'h0, CFG_RST});
    rd(8'h08, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CFG, {6'h00, c[2:0], 7'h60});
      rd(ADDR_CFG, {6'h00, c[2:0], 7'h63});
      `CHK(o_hyst_qual_x10, 10'h25D - 10'h02D * c[2:0])
      `CHK(o_hyst_code, c[2:0])
    end
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CFG, {3'h0, CFG_RST[12:4], c[1:0], 2'h3});
      tick;
      `CHK({o_ext_pulse_out_en, o_ext_pulse_in_en}, {c != 0, c[1]})
      `CHK({o_fixed_gain, o_osc_stop, o_sync_clk_from_pins}, {3{c == 3}})
      `CHK(o_test_mode, c == 3)
      pulse(2'h1, no, ns);
      `CHK(no, c != 0 ? PULSE_CYC : 0)
      `CHK(ns, c[1] ? 0 : PULSE_CYC)
      pulse(2'h2, no, ns);
      `CHK(ns, c[1] ? PULSE_CYC : 0)
    end
    for (int c = 0; c < 2; c++) begin
      @(posedge i_clock);
      i_servo_field_select <= c[0];
      settle;
      `CHK(o_hyst_ref_servo_field, c[0])
    end
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CFG, k ? 16'h1EA3 : 16'h1EE3);
      count_high(o_amp_input_clamp, 2000, n);
      @(posedge i_clock);
      i_signal_present <= 1'b1;
      i_write_gate <= 1'b0;
      settle;
      `CHK({o_amp_input_clamp, o_agc_hold, o_amp_input_block}, 3'h7)
      `CHK(o_agc_update_en, 1'b0)
      rd(ADDR_STAT, 16'h0003);
      @(posedge i_clock);
      i_write_gate <= 1'b1;
      count_high(o_agc_hold, 20, n);
      count_high(o_amp_input_clamp, 2000, n);
      `CHK(n, k ? CLAMP_LONG_CYC : CLAMP_SHORT_CYC)
      `CHK(o_agc_update_en, 1'b1)
      @(posedge i_clock);
      i_signal_present <= 1'b0;
      settle;
      `CHK(o_agc_update_en, 1'b0)
    end
    seek = 1'b0;
    bad = 1'b1;
    for (int v = 0; v < 32; v++) begin
      @(posedge i_clock);
      cmd <= v[4:0];
      qual <= v[0];
      if (!v[4] && v[0] != v[2])
        seek = v[2];
      e = {v[4] ? v[3:0] : 4'h0, !v[4] && v[3], !v[4] && v[1], seek};
      settle;
      g = {o_servo_gate, o_servo_discharge, o_obs_mode, o_seek_mode};
      `CHK(g, e)
      `CHK(o_servo_cap_four_obs, !v[4] && v[1] && v[0])
      `CHK(o_servo_cap_three_obs, 1'b0)
      rd(ADDR_STAT, {5'h00, !v[4] && v[0] && v[2], e, 3'h0});
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
